// [rtl/qls_pkg.sv]
// shared constants and carrier types for the quad low-side serial control
package qls_pkg;

  // ------------------------------------------------------------
  // channel count and clock
  // ------------------------------------------------------------
  localparam int NCH = 4;              // one holding bit per channel
  localparam int CLK_PERIOD_NS = 10;   // 100 MHz system clock

  // least time in ns to whole cycles, never below one cycle
  function automatic int qls_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ------------------------------------------------------------
  // protection timing
  // ------------------------------------------------------------
  localparam int OL_DEGLITCH_NS = 15000;     // open-load qualify time
  localparam int OCP_DEGLITCH_NS = 3500;     // current limit qualify
  localparam int RETRY_NS = 1200000;         // overcurrent off time
  localparam int OL_CYC = qls_cycles(OL_DEGLITCH_NS);
  localparam int OCP_CYC = qls_cycles(OCP_DEGLITCH_NS);
  localparam int RETRY_CYC = qls_cycles(RETRY_NS);
  localparam int POR_CYC = 16;               // internal power-up hold
  localparam int DEG_W = 11;                 // deglitch counter width
  localparam int RETRY_W = 17;               // retry counter width
  localparam int POR_W = 5;                  // power-up counter width
  localparam logic [DEG_W-1:0] OL_LAST = DEG_W'(OL_CYC - 1);
  localparam logic [DEG_W-1:0] OCP_LAST = DEG_W'(OCP_CYC - 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYC - 1);

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam int CTRL_DRV_OFF_BIT = 0;       // forces all drivers off
  localparam int CTRL_SW_RST_BIT = 1;        // holds core logic in reset
  localparam logic [1:0] CTRL_RST_VAL = 2'h0;
  localparam int ST_OUT_LSB = 0;             // output stage bits
  localparam int ST_OL_LSB = 4;              // open-load flags
  localparam int ST_OCP_LSB = 8;             // overcurrent flags
  localparam int ST_OT_BIT = 12;             // overtemperature seen
  localparam int ST_UV_BIT = 13;             // undervoltage seen
  localparam int ST_FPIN_BIT = 14;           // shared fault wire level
  localparam logic [NCH-1:0] CHAN_RST_VAL = 4'h0;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  // analog comparators per channel
  typedef struct packed {
    logic [NCH-1:0] pinLow;     // pin below open-load threshold
    logic [NCH-1:0] curLimit;   // analog current limit active
  } qls_sense_type;

  // every input that arrives from outside the clock domain
  typedef struct packed {
    logic shiftClock;
    logic latchStrobe;
    logic serialIn;
    logic outputEnableN;
    logic resetPin;
    logic overTemp;
    logic underVoltage;
    logic motorSupplyOk;
    logic faultOutNIn;
    logic [NCH-1:0] pinLow;
    logic [NCH-1:0] curLimit;
  } qls_pins_type;

  localparam qls_pins_type PINS_RST_VAL = '0;

endpackage

// [rtl/qls_serial_ctrl.sv]
// serial control and fault reporting core of a quad protected low-side driver
`timescale 1ns/1ps
`default_nettype none

module qls_serial_ctrl #(
  parameter int RetryCycles = qls_pkg::RETRY_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [qls_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire logic serialIn,
  input wire logic shiftClock,
  input wire logic latchStrobe,
  output logic serialOut,
  // control and supervision pins
  input wire logic outputEnableN,
  input wire logic resetPin,
  input wire logic overTemp,
  input wire logic underVoltage,
  input wire logic motorSupplyOk,
  // analog sense
  input wire qls_pkg::qls_sense_type sense,
  // drivers
  output logic [qls_pkg::NCH-1:0] driveOn,
  // open-drain fault pin
  input wire logic faultOutNIn,
  output logic faultOutNOut,
  output logic faultOutNOeN
);

  localparam logic [qls_pkg::RETRY_W-1:0] RETRY_LAST =
    qls_pkg::RETRY_W'(RetryCycles - 1);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  qls_pkg::qls_pins_type pinsRaw;    // raw pins gathered
  qls_pkg::qls_pins_type syncA_q;    // first stage, read by syncB only
  qls_pkg::qls_pins_type syncB_q;
  qls_pkg::qls_pins_type syncC_q;
  qls_pkg::qls_pins_type pinF_q;     // filtered, stable levels
  qls_pkg::qls_pins_type pinF_d;

  assign pinsRaw = '{shiftClock: shiftClock, latchStrobe: latchStrobe,
                     serialIn: serialIn, outputEnableN: outputEnableN,
                     resetPin: resetPin, overTemp: overTemp,
                     underVoltage: underVoltage,
                     motorSupplyOk: motorSupplyOk,
                     faultOutNIn: faultOutNIn,
                     pinLow: sense.pinLow, curLimit: sense.curLimit};

  // a bit only moves once the second and third stage agree
  assign pinF_d = (~(syncB_q ^ syncC_q) & syncB_q) |
                  ((syncB_q ^ syncC_q) & pinF_q);

  // synchroniser chain, reset only by the system reset
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_q <= qls_pkg::PINS_RST_VAL;
      syncB_q <= qls_pkg::PINS_RST_VAL;
      syncC_q <= qls_pkg::PINS_RST_VAL;
      pinF_q <= qls_pkg::PINS_RST_VAL;
    end else if (ce) begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      pinF_q <= pinF_d;
    end
  end

  // ------------------------------------------------------------
  // register bus slave
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;           // software control bits
  logic rdy_q;                  // access phase may complete
  logic [31:0] prdata_q;
  logic [31:0] statusWord;
  logic hitCtrl;
  logic hitStatus;
  logic setupPhase;
  logic accessDone;
  logic ctrlWrite;
  logic drvOffSw;
  logic swReset;

  assign hitCtrl = (paddr == qls_pkg::CTRL_OFS);
  assign hitStatus = (paddr == qls_pkg::STATUS_OFS);
  assign setupPhase = ce & psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign ctrlWrite = accessDone & pwrite & hitCtrl;
  assign drvOffSw = ctrl_q[qls_pkg::CTRL_DRV_OFF_BIT];
  assign swReset = ctrl_q[qls_pkg::CTRL_SW_RST_BIT];
  // ready only after the data was sampled in the setup cycle
  assign pready = ce & rdy_q;
  // unmapped addresses answer with an error, writes there are dropped
  assign pslverr = accessDone & ~(hitCtrl | hitStatus);
  assign prdata = prdata_q;

  // bus registers live outside the core reset so software stays in charge
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= qls_pkg::CTRL_RST_VAL;
      rdy_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      if (ctrlWrite) begin
        ctrl_q <= pwdata[1:0];
      end
      if (setupPhase) begin
        rdy_q <= 1'b1;
        prdata_q <= hitCtrl ? {30'h0, ctrl_q} :
                    (hitStatus ? statusWord : 32'h0);
      end else if (accessDone) begin
        rdy_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // core reset sources
  // ------------------------------------------------------------
  logic [qls_pkg::POR_W-1:0] porCnt_q;
  logic porBusy;
  logic intRst;

  assign porBusy = (porCnt_q != qls_pkg::POR_LAST);
  // supply loss and undervoltage behave as a held reset
  assign intRst = rst | porBusy | pinF_q.resetPin |
                  pinF_q.underVoltage | ~pinF_q.motorSupplyOk |
                  swReset;

  // power-up hold so no reset pulse is needed from the host
  always_ff @(posedge clk) begin
    if (rst) begin
      porCnt_q <= '0;
    end else if (ce && porBusy) begin
      porCnt_q <= porCnt_q + 5'h1;
    end
  end

  // ------------------------------------------------------------
  // edge detection on the link
  // ------------------------------------------------------------
  logic sclkPrev_q;
  logic latchPrev_q;
  logic sclkRise;
  logic sclkFall;
  logic latchRise;
  logic latchHigh;

  assign latchHigh = pinF_q.latchStrobe;
  assign sclkRise = pinF_q.shiftClock & ~sclkPrev_q;
  assign sclkFall = ~pinF_q.shiftClock & sclkPrev_q;
  assign latchRise = latchHigh & ~latchPrev_q;

  // previous levels, tracked even in core reset to avoid false edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
      latchPrev_q <= 1'b0;
    end else if (ce) begin
      sclkPrev_q <= pinF_q.shiftClock;
      latchPrev_q <= latchHigh;
    end
  end

  // ------------------------------------------------------------
  // holding shift register and output stage
  // ------------------------------------------------------------
  logic [qls_pkg::NCH-1:0] shift_q;    // holding register, bit3 leaves
  logic [qls_pkg::NCH-1:0] shift_d;
  logic [qls_pkg::NCH-1:0] out_q;      // output stage
  logic capPend_q;                     // fault capture still owed
  logic capPend_d;
  logic [qls_pkg::NCH-1:0] faultBits;
  logic capArm;

  assign capArm = capPend_q | latchRise;

  // shift in on rising edges while latch low, fault read on falling
  always_comb begin
    shift_d = shift_q;
    capPend_d = capPend_q;
    if (latchRise) begin
      capPend_d = 1'b1;
    end
    if (sclkRise && !latchHigh) begin
      shift_d = {shift_q[2:0], pinF_q.serialIn};
    end else if (sclkFall && latchHigh) begin
      if (capArm) begin
        shift_d = faultBits;
        capPend_d = 1'b0;
      end else begin
        shift_d = {shift_q[2:0], pinF_q.serialIn};
      end
    end
    if (!latchHigh) begin
      capPend_d = 1'b0;
    end
  end

  // serial state, cleared by every core reset source
  always_ff @(posedge clk) begin
    if (intRst) begin
      shift_q <= qls_pkg::CHAN_RST_VAL;
      out_q <= qls_pkg::CHAN_RST_VAL;
      capPend_q <= 1'b0;
    end else if (ce) begin
      shift_q <= shift_d;
      capPend_q <= capPend_d;
      if (latchRise) begin
        out_q <= shift_q;
      end
    end
  end

  // a register stage, so a chained part sees a clean level
  assign serialOut = shift_q[qls_pkg::NCH-1];

  // ------------------------------------------------------------
  // per-channel protection
  // ------------------------------------------------------------
  logic [qls_pkg::NCH-1:0][qls_pkg::DEG_W-1:0] olCnt_q;
  logic [qls_pkg::NCH-1:0][qls_pkg::DEG_W-1:0] olCnt_d;
  logic [qls_pkg::NCH-1:0][qls_pkg::DEG_W-1:0] ocpCnt_q;
  logic [qls_pkg::NCH-1:0][qls_pkg::DEG_W-1:0] ocpCnt_d;
  logic [qls_pkg::NCH-1:0][qls_pkg::RETRY_W-1:0] retryCnt_q;
  logic [qls_pkg::NCH-1:0][qls_pkg::RETRY_W-1:0] retryCnt_d;
  logic [qls_pkg::NCH-1:0] olFlag_q;
  logic [qls_pkg::NCH-1:0] olFlag_d;
  logic [qls_pkg::NCH-1:0] ocpFlag_q;
  logic [qls_pkg::NCH-1:0] ocpFlag_d;
  logic [qls_pkg::NCH-1:0] driveW;     // driver request this cycle
  logic [qls_pkg::NCH-1:0] driveOn_q;
  logic [qls_pkg::NCH-1:0] olSet;
  logic [qls_pkg::NCH-1:0] ocpSet;
  logic [qls_pkg::NCH-1:0] retryDone;
  logic globalOff;

  // enable pin, overtemperature and software gate all channels
  assign globalOff = pinF_q.outputEnableN | pinF_q.overTemp |
                     drvOffSw;
  assign driveW = out_q & ~ocpFlag_q & {qls_pkg::NCH{~globalOff}};
  assign faultBits = ocpFlag_q | olFlag_q;

  // deglitch and retry timers; a set always beats a clear
  always_comb begin
    for (int i = 0; i < qls_pkg::NCH; i++) begin
      olCnt_d[i] = '0;
      ocpCnt_d[i] = '0;
      retryCnt_d[i] = '0;
      // only counted while the control bit is off, so no fight with clear
      olSet[i] = ~out_q[i] & pinF_q.pinLow[i] &
                 (olCnt_q[i] == qls_pkg::OL_LAST);
      if (!out_q[i] && pinF_q.pinLow[i] && !olSet[i]) begin
        olCnt_d[i] = olCnt_q[i] + 11'h1;
      end
      ocpSet[i] = driveW[i] & pinF_q.curLimit[i] &
                  (ocpCnt_q[i] == qls_pkg::OCP_LAST);
      if (driveW[i] && pinF_q.curLimit[i] && !ocpSet[i]) begin
        ocpCnt_d[i] = ocpCnt_q[i] + 11'h1;
      end
      retryDone[i] = ocpFlag_q[i] & (retryCnt_q[i] == RETRY_LAST);
      if (ocpFlag_q[i] && !retryDone[i]) begin
        retryCnt_d[i] = retryCnt_q[i] + 17'h1;
      end
      if (olSet[i]) begin
        olFlag_d[i] = 1'b1;
      end else if (out_q[i]) begin
        olFlag_d[i] = 1'b0;
      end else begin
        olFlag_d[i] = olFlag_q[i];
      end
      if (ocpSet[i]) begin
        ocpFlag_d[i] = 1'b1;
      end else if (!out_q[i] || retryDone[i]) begin
        ocpFlag_d[i] = 1'b0;
      end else begin
        ocpFlag_d[i] = ocpFlag_q[i];
      end
    end
  end

  // protection state registers
  always_ff @(posedge clk) begin
    if (intRst) begin
      olCnt_q <= '0;
      ocpCnt_q <= '0;
      retryCnt_q <= '0;
      olFlag_q <= qls_pkg::CHAN_RST_VAL;
      ocpFlag_q <= qls_pkg::CHAN_RST_VAL;
      driveOn_q <= qls_pkg::CHAN_RST_VAL;
    end else if (ce) begin
      olCnt_q <= olCnt_d;
      ocpCnt_q <= ocpCnt_d;
      retryCnt_q <= retryCnt_d;
      olFlag_q <= olFlag_d;
      ocpFlag_q <= ocpFlag_d;
      driveOn_q <= driveW;
    end
  end

  assign driveOn = driveOn_q;

  // ------------------------------------------------------------
  // fault pin and status
  // ------------------------------------------------------------
  logic faultOeN_q;

  // open drain: released (enable high) when nothing is wrong
  always_ff @(posedge clk) begin
    if (rst) begin
      faultOeN_q <= 1'b1;
    end else if (ce) begin
      faultOeN_q <= ~((|faultBits) | pinF_q.overTemp);
    end
  end

  assign faultOutNOut = 1'b0;
  assign faultOutNOeN = faultOeN_q;

  // status word gathers the live core state
  always_comb begin
    statusWord = 32'h0;
    statusWord[qls_pkg::ST_OUT_LSB +: qls_pkg::NCH] = out_q;
    statusWord[qls_pkg::ST_OL_LSB +: qls_pkg::NCH] = olFlag_q;
    statusWord[qls_pkg::ST_OCP_LSB +: qls_pkg::NCH] = ocpFlag_q;
    statusWord[qls_pkg::ST_OT_BIT] = pinF_q.overTemp;
    statusWord[qls_pkg::ST_UV_BIT] = pinF_q.underVoltage;
    statusWord[qls_pkg::ST_FPIN_BIT] = pinF_q.faultOutNIn;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_SHIFT_IN: assert property (
    (ce && sclkRise && !latchHigh && !intRst) |=>
      shift_q == {$past(shift_q[2:0]), $past(pinF_q.serialIn)})
    else $error("holding register did not shift on rising edge");

  AST_CHAIN_OUT: assert property (
    (ce && sclkRise && !latchHigh && !intRst) |=>
      serialOut == $past(shift_q[2]))
    else $error("serial out did not advance by one stage");

  AST_LATCH_COPY: assert property (
    (ce && latchRise && !intRst) |=> out_q == $past(shift_q))
    else $error("output stage not loaded on latch edge");

  AST_FAULT_CAPTURE: assert property (
    (ce && sclkFall && latchHigh && capArm && !intRst) |=>
      shift_q == $past(faultBits))
    else $error("fault bits not captured on first falling edge");

  AST_OL_SET: assert property (
    (ce && !intRst && !out_q[0] && pinF_q.pinLow[0] &&
     olCnt_q[0] == qls_pkg::OL_LAST) |=> olFlag_q[0])
    else $error("open-load flag not set after qualify time");

  AST_OL_CLEAR: assert property (
    (ce && !intRst && out_q[0]) |=> !olFlag_q[0])
    else $error("open-load flag survived a set output bit");

  AST_OCP_OFF: assert property (
    (ce && !intRst && ocpFlag_q[0]) |=> !driveOn[0])
    else $error("driver on while overcurrent flagged");

  AST_OCP_CLEAR: assert property (
    (ce && !intRst && !out_q[0]) |=> !ocpFlag_q[0])
    else $error("overcurrent flag survived a cleared output bit");

  AST_FAULT_PIN: assert property (
    (ce && ((|faultBits) || pinF_q.overTemp)) |=> !faultOutNOeN)
    else $error("fault pin released during a fault");

  AST_ENABLE_GATE: assert property (
    (ce && pinF_q.outputEnableN) |=> driveOn == '0)
    else $error("driver on while output enable high");

  AST_RESET_CLEAR: assert property (
    intRst |=> (shift_q == '0 && out_q == '0 && ocpFlag_q == '0))
    else $error("core reset left serial or fault state");

endmodule

`default_nettype wire

// [tb/qls_host_model.sv]
// host side model that drives the serial chain of one device
`timescale 1ns/1ps
`default_nettype none

module qls_host_model (
  // clock
  input wire logic clk,
  // serial link
  input wire logic serialOut,
  output logic shiftClock,
  output logic latchStrobe,
  output logic serialIn
);
  logic [1:0] ph = 2'h0; // 6,6,6,7 cycle halves average 62.5 ns
  // link clock idles low outside frames
  initial begin
    shiftClock = 1'b0;
    latchStrobe = 1'b0;
    serialIn = 1'b0;
  end
  // one half period of the link clock
  task automatic half();
    repeat ((ph == 2'h3) ? 7 : 6) @(posedge clk);
    ph = ph + 2'h1;
  endtask
  // write four bits, latch them, read four fault bits back
  task automatic xfer(input logic [3:0] wr, output logic [3:0] flt,
                      output logic so);
    @(posedge clk);
    // data moves on the falling edge, so each bit sits a half period
    // before and after the rising edge that takes it
    for (int i = 3; i >= 0; i--) begin
      serialIn <= wr[i];
      half();
      shiftClock <= 1'b1;
      half();
      so = serialOut;
      shiftClock <= 1'b0;
    end
    @(posedge clk);
    latchStrobe <= 1'b1;
    serialIn <= ~wr[0]; // line past hold shows the inverse
    repeat (25) @(posedge clk);
    shiftClock <= 1'b1;
    // the same 6,6,6,7 cycle halves keep the read-back period at the nominal rate
    for (int j = 3; j >= 0; j--) begin
      half();
      shiftClock <= 1'b0; // first fall captures, later ones shift
      half();
      flt[j] = serialOut;
      shiftClock <= 1'b1;
    end
    half();
    latchStrobe <= 1'b0;
    half();
    shiftClock <= 1'b0; // falling edge with latch low does nothing
  endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the quad low-side serial control core
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // clock enable, dropped once to check the freeze
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic outputEnableN = 1'b0, resetPin = 1'b0, overTemp = 1'b0;
  logic underVoltage = 1'b0, motorSupplyOk = 1'b1;
  qls_pkg::qls_sense_type sense = '0; // analog comparators
  logic serialIn, shiftClock, latchStrobe, serialOut;
  logic [3:0] driveOn;
  logic faultOutNOut, faultOutNOeN;
  wire logic faultWire; // pulled up unless a device sinks it
  int n_errors = 0, comparisons = 0;
  logic [3:0] flt;
  logic so, er;
  logic [31:0] rd;
  assign faultWire = faultOutNOeN ? 1'b1 : faultOutNOut;
  always #5 clk = ~clk;
  // short retry so the off time fits the run
  qls_serial_ctrl #(.RetryCycles(400)) i_dut (.clk(clk), .rst(rst),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialIn(serialIn), .shiftClock(shiftClock),
    .latchStrobe(latchStrobe), .serialOut(serialOut),
    .outputEnableN(outputEnableN), .resetPin(resetPin),
    .overTemp(overTemp), .underVoltage(underVoltage),
    .motorSupplyOk(motorSupplyOk), .sense(sense), .driveOn(driveOn),
    .faultOutNIn(faultWire), .faultOutNOut(faultOutNOut),
    .faultOutNOeN(faultOutNOeN));
  qls_host_model i_host (.clk(clk), .serialOut(serialOut),
    .shiftClock(shiftClock), .latchStrobe(latchStrobe),
    .serialIn(serialIn));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // one apb transfer, waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // slave promises ready in the first access cycle
    chk(32'(n), 32'h1, "apb wait states");
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk(32'(driveOn), 32'h0, "drive after reset");
    chk(32'(faultOutNOeN), 32'h1, "fault wire after reset");
    chk(32'(serialOut), 32'h0, "chain out after reset");
    apb(1'b0, qls_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0, "ctrl reset value");
    apb(1'b0, qls_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h00004000, "status reset value");
    apb(1'b1, qls_pkg::CTRL_OFS, 32'hffffffff);
    apb(1'b0, qls_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h3, "ctrl readback");
    apb(1'b1, qls_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, 12'h008, 32'h1);
    chk(32'(er), 32'h1, "unmapped write error");
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    apb(1'b1, qls_pkg::STATUS_OFS, 32'h1);
    chk(32'(er), 32'h0, "status write no error");
    wait_clk(40);
  endtask
  task automatic t_write();
    logic [3:0] p[2] = '{4'ha, 4'h5};
    foreach (p[k]) begin
      i_host.xfer(p[k], flt, so);
      chk(32'(driveOn), 32'(p[k]), "outputs after latch");
      chk(32'(so), 32'(p[k][3]), "chain out last stage");
      chk(32'(flt), 32'h0, "no fault bits");
    end
    // a frozen core must not even see the enable pin move
    ce <= 1'b0;
    outputEnableN <= 1'b1;
    wait_clk(10);
    chk(32'(driveOn), 32'h5, "frozen while clock enable low");
    ce <= 1'b1;
    wait_clk(10);
    chk(32'(driveOn), 32'h0, "disabled drivers");
    i_host.xfer(4'h3, flt, so);
    outputEnableN <= 1'b0;
    wait_clk(10);
    chk(32'(driveOn), 32'h3, "serial works while disabled");
  endtask
  task automatic t_open();
    i_host.xfer(4'h0, flt, so);
    sense.pinLow <= 4'h1;
    wait_clk(1400);
    chk(32'(faultOutNOeN), 32'h1, "open load too early");
    wait_clk(200);
    chk(32'(faultOutNOeN), 32'h0, "open load pulls fault");
    apb(1'b0, qls_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h00000010, "status shows open load");
    i_host.xfer(4'h0, flt, so);
    chk(32'(flt), 32'h1, "fault bits read out");
    i_host.xfer(4'h1, flt, so);
    chk(32'(faultOutNOeN), 32'h1, "open load cleared");
    sense.pinLow <= 4'h0;
  endtask
  // channel 0 on, current limit held past the qualify time
  task automatic trip();
    i_host.xfer(4'h1, flt, so);
    sense.curLimit <= 4'h1;
    wait_clk(300);
    chk(32'(driveOn), 32'h1, "on during qualify");
    wait_clk(100);
    sense.curLimit <= 4'h0;
    chk(32'(driveOn), 32'h0, "off after overcurrent");
    chk(32'(faultOutNOeN), 32'h0, "overcurrent fault");
  endtask
  task automatic t_ocp();
    trip();
    wait_clk(200);
    chk(32'(driveOn), 32'h0, "off in retry");
    wait_clk(250);
    chk({driveOn, faultOutNOeN}, 32'h3, "cleared after retry");
    trip();
    i_host.xfer(4'h0, flt, so);
    chk(32'(faultOutNOeN), 32'h1, "flag cleared by bit");
    trip();
    resetPin <= 1'b1;
    wait_clk(10);
    chk({driveOn, faultOutNOeN}, 32'h1, "reset pin clears");
    resetPin <= 1'b0;
    wait_clk(10);
    trip();
    motorSupplyOk <= 1'b0;
    wait_clk(10);
    chk(32'(faultOutNOeN), 32'h1, "supply loss clears");
    motorSupplyOk <= 1'b1;
    wait_clk(10);
  endtask
  task automatic t_hot_low();
    i_host.xfer(4'hf, flt, so);
    overTemp <= 1'b1;
    wait_clk(10);
    chk({driveOn, faultOutNOeN}, 32'h0, "overtemp shutdown");
    overTemp <= 1'b0;
    wait_clk(10);
    chk({driveOn, faultOutNOeN}, 32'h1f, "overtemp resume");
    underVoltage <= 1'b1;
    wait_clk(10);
    chk(32'(driveOn), 32'h0, "undervoltage off");
    underVoltage <= 1'b0;
    wait_clk(10);
    chk(32'(driveOn), 32'h0, "undervoltage reset");
    i_host.xfer(4'h2, flt, so);
    chk(32'(driveOn), 32'h2, "resume after supply");
    // software gate, then software core reset
    apb(1'b1, qls_pkg::CTRL_OFS, 32'h1);
    wait_clk(2);
    chk(32'(driveOn), 32'h0, "software drive off");
    apb(1'b1, qls_pkg::CTRL_OFS, 32'h2);
    apb(1'b1, qls_pkg::CTRL_OFS, 32'h0);
    wait_clk(2);
    chk(32'(driveOn), 32'h0, "software core reset");
  endtask
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    wait_clk(10);
    rst <= 1'b0;
    wait_clk(40);
    t_regs();
    t_write();
    t_open();
    t_ocp();
    t_hot_low();
    give_verdict();
  end
  // whole run is near 5700 cycles
  initial begin
    wait_clk(60000);
    n_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
